// ---- inc/acc_pkg.sv ----
// Constants and types for the channel configuration and calibration set.
// Assumes a classic Wishbone slave with 32-bit data, one word per register.
`default_nettype none
package acc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0]  ACC_IDX_CFG      = 8'h13;
    localparam logic [7:0]  ACC_IDX_OCAL_HI  = 8'h14;
    localparam logic [7:0]  ACC_IDX_OCAL_LO  = 8'h15;
    localparam logic [7:0]  ACC_IDX_GCAL_HI  = 8'h16;
    localparam logic [7:0]  ACC_IDX_GCAL_LO  = 8'h17;
    localparam logic [7:0]  ACC_IDX_NEXT_CFG = 8'h18;
    localparam int          ACC_IDX_LSB      = 2;
    localparam int          ACC_IDX_W        = 8;
    localparam int          ACC_REG_W        = 16;
    localparam int          ACC_CAL_W        = 24;
    localparam int          ACC_PHASE_HI     = 15;
    localparam int          ACC_PHASE_LO     = 6;
    localparam int          ACC_DCB_BIT      = 2;
    localparam int          ACC_MUX_HI       = 1;
    localparam int          ACC_LOBYTE_HI    = 15;
    localparam int          ACC_LOBYTE_LO    = 8;
    localparam logic [15:0] ACC_CFG_MASK     = 16'hffc7;
    localparam logic [15:0] ACC_LO_MASK      = 16'hff00;
    localparam logic [15:0] ACC_CFG_RST      = 16'h0000;
    localparam logic [15:0] ACC_OCAL_HI_RST  = 16'h0000;
    localparam logic [15:0] ACC_OCAL_LO_RST  = 16'h0000;
    localparam logic [15:0] ACC_GCAL_HI_RST  = 16'h8000;
    localparam logic [15:0] ACC_GCAL_LO_RST  = 16'h0000;

    typedef enum logic [1:0] {
        ACC_IN_PINS  = 2'h0,
        ACC_IN_SHORT = 2'h1,
        ACC_IN_POS   = 2'h2,
        ACC_IN_NEG   = 2'h3
    } acc_input_sel_t;

    typedef struct packed {
        logic [9:0]     chan_phase_delay;
        logic           chan_dc_block_off;
        acc_input_sel_t chan_input_select;
    } acc_chan_cfg_t;

    typedef struct packed {
        logic [23:0] offset_cal;
        logic [23:0] gain_cal;
    } acc_cal_t;
endpackage : acc_pkg
`default_nettype wire

// ---- core/acc_regs.sv ----
// Channel configuration and calibration registers on a Wishbone slave.
// Assumes a classic Wishbone master on core_clk; one-cycle ack or err per access.
`timescale 1ns/100ps
`default_nettype none
module acc_regs
    import acc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    input  wire logic        global_dc_block_setting,
    output acc_chan_cfg_t    chan_cfg,
    output acc_cal_t         chan_cal,
    output logic             chan_dc_block_active,
    output logic      [15:0] next_chan_config
);
    // =========================================================
    // Bus decode
    // =========================================================
    logic        req;
    logic [7:0]  idx;
    logic        hit;
    logic        wr;
    logic [15:0] wmask;
    logic [15:0] rd_val;
    logic [15:0] cfg_reg, cfg_next;
    logic [15:0] ocal_hi_reg, ocal_hi_next;
    logic [15:0] ocal_lo_reg, ocal_lo_next;
    logic [15:0] gcal_hi_reg, gcal_hi_next;
    logic [15:0] gcal_lo_reg, gcal_lo_next;
    logic [15:0] ncfg_reg, ncfg_next;
    logic        ack_reg, ack_next;
    logic        err_reg, err_next;
    logic [31:0] dat_reg, dat_next;

    assign req   = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
    assign idx   = wb_adr_i[ACC_IDX_LSB +: ACC_IDX_W];
    assign hit   = (wb_adr_i[1:0] == 2'h0) &&
                   (wb_adr_i[31:ACC_IDX_LSB+ACC_IDX_W] == 22'h000000) &&
                   (idx >= ACC_IDX_CFG) && (idx <= ACC_IDX_NEXT_CFG);
    assign wr    = req && hit && wb_we_i;
    assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [15:0] bm,
                                          input logic [15:0] fm);
        merge = ((old & ~bm) | (wd & bm)) & fm;
    endfunction

    // =========================================================
    // Register next state
    // =========================================================
    always_comb begin
        cfg_next     = cfg_reg;
        ocal_hi_next = ocal_hi_reg;
        ocal_lo_next = ocal_lo_reg;
        gcal_hi_next = gcal_hi_reg;
        gcal_lo_next = gcal_lo_reg;
        ncfg_next    = ncfg_reg;
        if (wr) begin
            case (idx)
                ACC_IDX_CFG: begin
                    cfg_next = merge(cfg_reg, wb_dat_i[15:0], wmask,
                                     ACC_CFG_MASK);
                end
                ACC_IDX_OCAL_HI: begin
                    ocal_hi_next = merge(ocal_hi_reg, wb_dat_i[15:0],
                                         wmask, 16'hffff);
                end
                ACC_IDX_OCAL_LO: begin
                    ocal_lo_next = merge(ocal_lo_reg, wb_dat_i[15:0],
                                         wmask, ACC_LO_MASK);
                end
                ACC_IDX_GCAL_HI: begin
                    gcal_hi_next = merge(gcal_hi_reg, wb_dat_i[15:0],
                                         wmask, 16'hffff);
                end
                ACC_IDX_GCAL_LO: begin
                    gcal_lo_next = merge(gcal_lo_reg, wb_dat_i[15:0],
                                         wmask, ACC_LO_MASK);
                end
                ACC_IDX_NEXT_CFG: begin
                    ncfg_next = merge(ncfg_reg, wb_dat_i[15:0], wmask,
                                      ACC_CFG_MASK);
                end
                default: begin
                    cfg_next = cfg_reg;
                end
            endcase
        end
    end

    // =========================================================
    // Read mux and answer
    // =========================================================
    always_comb begin
        case (idx)
            ACC_IDX_CFG:      rd_val = cfg_reg & ACC_CFG_MASK;
            ACC_IDX_OCAL_HI:  rd_val = ocal_hi_reg;
            ACC_IDX_OCAL_LO:  rd_val = ocal_lo_reg & ACC_LO_MASK;
            ACC_IDX_GCAL_HI:  rd_val = gcal_hi_reg;
            ACC_IDX_GCAL_LO:  rd_val = gcal_lo_reg & ACC_LO_MASK;
            ACC_IDX_NEXT_CFG: rd_val = ncfg_reg & ACC_CFG_MASK;
            default:          rd_val = 16'h0000;
        endcase
        ack_next = req && hit;
        err_next = req && !hit;
        dat_next = dat_reg;
        if (req && hit && !wb_we_i) begin
            dat_next = {16'h0000, rd_val};
        end else if (req) begin
            dat_next = 32'h00000000;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cfg_reg     <= ACC_CFG_RST;
            ocal_hi_reg <= ACC_OCAL_HI_RST;
            ocal_lo_reg <= ACC_OCAL_LO_RST;
            gcal_hi_reg <= ACC_GCAL_HI_RST;
            gcal_lo_reg <= ACC_GCAL_LO_RST;
            ncfg_reg    <= ACC_CFG_RST;
            ack_reg     <= 1'b0;
            err_reg     <= 1'b0;
            dat_reg     <= 32'h00000000;
        end else begin
            cfg_reg     <= cfg_next;
            ocal_hi_reg <= ocal_hi_next;
            ocal_lo_reg <= ocal_lo_next;
            gcal_hi_reg <= gcal_hi_next;
            gcal_lo_reg <= gcal_lo_next;
            ncfg_reg    <= ncfg_next;
            ack_reg     <= ack_next;
            err_reg     <= err_next;
            dat_reg     <= dat_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_err_o = err_reg;
    assign wb_dat_o = dat_reg;

    // =========================================================
    // Outputs to the channel datapath
    // =========================================================
    assign chan_cfg.chan_phase_delay  = cfg_reg[ACC_PHASE_HI:ACC_PHASE_LO];
    assign chan_cfg.chan_dc_block_off = cfg_reg[ACC_DCB_BIT];
    assign chan_cfg.chan_input_select =
        acc_input_sel_t'(cfg_reg[ACC_MUX_HI:0]);
    // Per-channel disable overrides the global setting
    assign chan_dc_block_active = global_dc_block_setting &&
                                  !cfg_reg[ACC_DCB_BIT];
    assign chan_cal.offset_cal = {ocal_hi_reg,
        ocal_lo_reg[ACC_LOBYTE_HI:ACC_LOBYTE_LO]};
    assign chan_cal.gain_cal   = {gcal_hi_reg,
        gcal_lo_reg[ACC_LOBYTE_HI:ACC_LOBYTE_LO]};
    assign next_chan_config    = ncfg_reg & ACC_CFG_MASK;

    // =========================================================
    // Checks
    // =========================================================
    property p_cfg_resv;
        @(posedge core_clk) disable iff (srst)
        (cfg_reg & ~ACC_CFG_MASK) == 16'h0000;
    endproperty
    a_cfg_resv: assert property (p_cfg_resv)
        else $error("reserved config bits set");

    property p_dcb;
        @(posedge core_clk) disable iff (srst)
        cfg_reg[ACC_DCB_BIT] |-> !chan_dc_block_active;
    endproperty
    a_dcb: assert property (p_dcb)
        else $error("dc block active while disabled");

    property p_mux;
        @(posedge core_clk) disable iff (srst)
        wr && idx == ACC_IDX_CFG && wb_sel_i[0] |=>
            chan_cfg.chan_input_select == $past(wb_dat_i[1:0]);
    endproperty
    a_mux: assert property (p_mux)
        else $error("input select not written");

    property p_ocal_hi;
        @(posedge core_clk) disable iff (srst)
        wr && idx == ACC_IDX_OCAL_HI && wb_sel_i[1:0] == 2'h3 |=>
            chan_cal.offset_cal[23:8] == $past(wb_dat_i[15:0]);
    endproperty
    a_ocal_hi: assert property (p_ocal_hi)
        else $error("offset high bits wrong");

    property p_ocal_lo;
        @(posedge core_clk) disable iff (srst)
        ocal_lo_reg[7:0] == 8'h00;
    endproperty
    a_ocal_lo: assert property (p_ocal_lo)
        else $error("offset low reserved byte set");

    property p_rst_ocal;
        @(posedge core_clk)
        srst |=> ocal_hi_reg == 16'h0000;
    endproperty
    a_rst_ocal: assert property (p_rst_ocal)
        else $error("offset high reset wrong");

    property p_gcal_hi;
        @(posedge core_clk) disable iff (srst)
        wr && idx == ACC_IDX_GCAL_HI && wb_sel_i[1:0] == 2'h3 |=>
            chan_cal.gain_cal[23:8] == $past(wb_dat_i[15:0]);
    endproperty
    a_gcal_hi: assert property (p_gcal_hi)
        else $error("gain high bits wrong");

    property p_rst_gcal;
        @(posedge core_clk)
        srst |=> chan_cal.gain_cal ==
            {ACC_GCAL_HI_RST, ACC_GCAL_LO_RST[ACC_LOBYTE_HI:ACC_LOBYTE_LO]};
    endproperty
    a_rst_gcal: assert property (p_rst_gcal)
        else $error("gain reset wrong");

    property p_gcal_lo;
        @(posedge core_clk) disable iff (srst)
        wr && idx == ACC_IDX_GCAL_LO && wb_sel_i[1] |=>
            chan_cal.gain_cal[7:0] == $past(wb_dat_i[15:8]) &&
            gcal_lo_reg[7:0] == 8'h00;
    endproperty
    a_gcal_lo: assert property (p_gcal_lo)
        else $error("gain low byte wrong");

    property p_cat;
        @(posedge core_clk) disable iff (srst)
        chan_cal.offset_cal == {ocal_hi_reg, ocal_lo_reg[15:8]};
    endproperty
    a_cat: assert property (p_cat)
        else $error("offset word not concatenated");

    property p_phase;
        @(posedge core_clk) disable iff (srst)
        wr && idx == ACC_IDX_CFG && wb_sel_i[1:0] == 2'h3 |=>
            chan_cfg.chan_phase_delay ==
                $past(wb_dat_i[ACC_PHASE_HI:ACC_PHASE_LO]);
    endproperty
    a_phase: assert property (p_phase)
        else $error("phase delay not written");

    property p_cfg_rd;
        @(posedge core_clk) disable iff (srst)
        req && hit && !wb_we_i && idx == ACC_IDX_CFG |=>
            (wb_dat_o[15:0] & ~ACC_CFG_MASK) == 16'h0000;
    endproperty
    a_cfg_rd: assert property (p_cfg_rd)
        else $error("reserved config bits read back");

    property p_dcb_follow;
        @(posedge core_clk) disable iff (srst)
        !cfg_reg[ACC_DCB_BIT] |->
            chan_dc_block_active == global_dc_block_setting;
    endproperty
    a_dcb_follow: assert property (p_dcb_follow)
        else $error("dc block not following global setting");

    property p_rst_cfg;
        @(posedge core_clk)
        srst |=> chan_cfg.chan_input_select == ACC_IN_PINS &&
            !chan_cfg.chan_dc_block_off;
    endproperty
    a_rst_cfg: assert property (p_rst_cfg)
        else $error("config reset wrong");

    property p_refuse;
        @(posedge core_clk) disable iff (srst)
        req && !hit |=> wb_err_o && !wb_ack_o && $stable(ocal_hi_reg);
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("refused access changed offset high");

    property p_ocal_lo_wr;
        @(posedge core_clk) disable iff (srst)
        wr && idx == ACC_IDX_OCAL_LO && wb_sel_i[1] |=>
            chan_cal.offset_cal[7:0] ==
                $past(wb_dat_i[ACC_LOBYTE_HI:ACC_LOBYTE_LO]);
    endproperty
    a_ocal_lo_wr: assert property (p_ocal_lo_wr)
        else $error("offset low bits wrong");

    property p_gcal_rd;
        @(posedge core_clk) disable iff (srst)
        req && hit && !wb_we_i && idx == ACC_IDX_GCAL_LO |=>
            (wb_dat_o[15:0] & ~ACC_LO_MASK) == 16'h0000;
    endproperty
    a_gcal_rd: assert property (p_gcal_rd)
        else $error("gain low reserved byte read back");

    property p_gain_cat;
        @(posedge core_clk) disable iff (srst)
        chan_cal.gain_cal == {gcal_hi_reg,
            gcal_lo_reg[ACC_LOBYTE_HI:ACC_LOBYTE_LO]};
    endproperty
    a_gain_cat: assert property (p_gain_cat)
        else $error("gain word not concatenated");
endmodule // acc_regs
`default_nettype wire

// ---- testbench/acc_regs_test.sv ----
// Self-checking bench for the channel configuration and calibration set.
// Drives the classic Wishbone slave and side inputs directly, no partner.
`timescale 1ns/100ps
`default_nettype none
module acc_regs_test
    import acc_pkg::*;
;
    typedef struct packed {
        logic [31:0] adr;
        logic [15:0] wd;
        logic [15:0] rx;
    } acc_row_t;

    logic          core_clk = 1'b0;
    logic          srst;
    logic          wb_cyc_i;
    logic          wb_stb_i;
    logic          wb_we_i;
    logic   [31:0] wb_adr_i;
    logic   [31:0] wb_dat_i;
    logic   [3:0]  wb_sel_i;
    logic   [31:0] wb_dat_o;
    logic          wb_ack_o;
    logic          wb_err_o;
    logic          global_dc_block_setting;
    acc_chan_cfg_t chan_cfg;
    acc_cal_t      chan_cal;
    logic          chan_dc_block_active;
    logic   [15:0] next_chan_config;
    logic   [31:0] rd;
    logic          gerr;
    int            err_total = 0;
    int            total_checks = 0;
    int            cycles = 0;
    acc_row_t      rows [10] = '{
        '{32'h4c, 16'hffff, 16'hffc7}, '{32'h4c, 16'h8001, 16'h8001},
        '{32'h4c, 16'h0002, 16'h0002}, '{32'h4c, 16'h0007, 16'h0007},
        '{32'h50, 16'hffff, 16'hffff}, '{32'h50, 16'h1234, 16'h1234},
        '{32'h54, 16'hffff, 16'hff00}, '{32'h58, 16'ha5c3, 16'ha5c3},
        '{32'h5c, 16'hffff, 16'hff00}, '{32'h60, 16'hffff, 16'hffc7}};

    acc_regs u_acc_regs (
        .core_clk(core_clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .global_dc_block_setting(global_dc_block_setting),
        .chan_cfg(chan_cfg), .chan_cal(chan_cal),
        .chan_dc_block_active(chan_dc_block_active),
        .next_chan_config(next_chan_config));

    always #20 core_clk = ~core_clk;

    // =========================================================
    // Checks and bus cycles
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [47:0] exp,
                       input logic [47:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Holds the request until ack or err is sampled high
    task automatic wb(input logic w, input logic [31:0] a,
                      input logic [15:0] d, input logic [3:0] s);
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= {16'h0000, d};
        wb_sel_i <= s;
        do begin
            @(posedge core_clk);
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        rd = wb_dat_o;
        gerr = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic rdchk(input string what, input logic [31:0] a,
                         input logic [15:0] exp);
        wb(1'b0, a, 16'h0000, 4'h3);
        chk(what, {32'h0, exp}, {16'h0, rd});
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            err_total++;
            stop_test();
        end
    end

    // =========================================================
    // Main sequence
    initial begin
        srst <= 1'b1;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        wb_adr_i <= 32'h0;
        wb_dat_i <= 32'h0;
        wb_sel_i <= 4'h0;
        global_dc_block_setting <= 1'b1;
        repeat (20) @(posedge core_clk);
        srst <= 1'b0;
        rdchk("cfg rst", 32'h4c, 16'h0000);
        rdchk("ocal hi rst", 32'h50, 16'h0000);
        rdchk("gcal hi rst", 32'h58, 16'h8000);
        rdchk("gcal lo rst", 32'h5c, 16'h0000);
        chk("cal rst", {24'h0, 24'h800000}, chan_cal);
        $display("test reset done");
        foreach (rows[i]) begin
            wb(1'b1, rows[i].adr, rows[i].wd, 4'h3);
            rdchk("row", rows[i].adr, rows[i].rx);
        end
        chk("next cfg", 48'hffc7, next_chan_config);
        $display("test table done");
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, 32'h4c, 16'(i), 4'h3);
            chk("mux", 48'(i), chan_cfg.chan_input_select);
        end
        wb(1'b1, 32'h4c, 16'h8040, 4'h3);
        chk("phase", 48'h201, chan_cfg.chan_phase_delay);
        chk("dcb on", 48'h1, chan_dc_block_active);
        wb(1'b1, 32'h4c, 16'h0004, 4'h3);
        chk("dcb bit", 48'h1, chan_cfg.chan_dc_block_off);
        chk("dcb off", 48'h0, chan_dc_block_active);
        wb(1'b1, 32'h4c, 16'h0000, 4'h3);
        global_dc_block_setting <= 1'b0;
        @(posedge core_clk);
        @(posedge core_clk);
        chk("dcb global", 48'h0, chan_dc_block_active);
        $display("test config done");
        wb(1'b1, 32'h50, 16'h9999, 4'h1);
        rdchk("byte sel", 32'h50, 16'h1299);
        wb(1'b1, 32'h50, 16'h1234, 4'h3);
        wb(1'b1, 32'h54, 16'habff, 4'h3);
        wb(1'b1, 32'h58, 16'h5678, 4'h3);
        wb(1'b1, 32'h5c, 16'hcd00, 4'h3);
        chk("cal word", {24'h1234ab, 24'h5678cd}, chan_cal);
        $display("test calibration done");
        wb(1'b0, 32'h64, 16'h0000, 4'h3);
        chk("unmapped err", 48'h1, gerr);
        chk("unmapped data", 48'h0, rd);
        wb(1'b1, 32'h51, 16'hffff, 4'h3);
        chk("misaligned err", 48'h1, gerr);
        rdchk("no write", 32'h50, 16'h1234);
        $display("test refusal done");
        srst <= 1'b1;
        @(posedge core_clk);
        srst <= 1'b0;
        rdchk("gcal hi rerst", 32'h58, 16'h8000);
        rdchk("ocal hi rerst", 32'h50, 16'h0000);
        chk("cfg rerst", 48'h0, chan_cfg);
        $display("test second reset done");
        stop_test();
    end
endmodule // acc_regs_test
`default_nettype wire
